/* File: hdl/csp_map.vh */
// constants for the codec serial port front end
// included by csp_top.v; definitions only
`ifndef CSP_MAP_VH
`define CSP_MAP_VH
// clock and frame timing: clock rate in Hz, divider and start points in CLK cycles
`define CSP_CLK_HZ        10000000
`define CSP_SAMPLE_DIV    512
`define CSP_CNT_W         9
`define CSP_PRI_START     9'h000
`define CSP_SEC_START     9'h100
`define CSP_FRAME_EDGES   5'h10
`define CSP_WORD_W        16
// secondary word fields
`define CSP_SEC_RD_BIT    13
`define CSP_SEC_ADDR_HI   9
`define CSP_SEC_ADDR_LO   8
`define CSP_SEC_DATA_HI   7
`define CSP_SEC_DATA_LO   0
`define CSP_ADDR_NOP      2'h0
`define CSP_ADDR_CTRL1    2'h1
`define CSP_ADDR_CTRL2    2'h2
// control 1 fields
`define CSP_C1_SWRST      7
`define CSP_C1_SWPD       6
`define CSP_C1_AUX        5
`define CSP_C1_LOOP       4
`define CSP_C1_M15        3
`define CSP_C1_MON_HI     2
`define CSP_C1_MON_LO     1
`define CSP_C1_RESET      8'h00
// control 2 fields
`define CSP_C2_OVF        7
`define CSP_C2_PHONE      2
`define CSP_C2_FLAG1      1
`define CSP_C2_FLAG0      0
`define CSP_C2_RESET      8'h00
`define CSP_C2_WMASK      8'h07
// bus map, byte addresses
`define CSP_AV_STATUS     4'h0
`define CSP_AV_CMD        4'h4
`define CSP_AV_LASTSEC    4'h8
`define CSP_CMD_SECREQ    0
// adc word buffer
`define CSP_BUF_DEPTH     2
`endif

/* File: hdl/csp_top.v */
// codec serial port: shift clock, frame sync, serial shifters,
// control registers 1 and 2, adc word buffer and an avalon-mm slave.
// assumes SDATA_IN, FC_PIN and POWER_DOWN_PIN_N come from outside the
// CLK domain; ADC_*, DAC_READY-free stream and OVF_EVENT come from logic
// on CLK. the board resolves SDATA_OUT/SDATA_OUT_OE into a three-state pin.
//
// The implementer's own choices: the Avalon-MM interface to the registers and the register offsets.
`include "csp_map.vh"
`timescale 1ns/10ps
`default_nettype none

module csp_top (
	input  wire        CLK,
	input  wire        RST,
	input  wire        CE,
	input  wire [3:0]  AVS_ADDRESS,
	input  wire        AVS_READ,
	input  wire        AVS_WRITE,
	input  wire [31:0] AVS_WRITEDATA,
	output reg  [31:0] AVS_READDATA,
	output reg         AVS_WAITREQUEST,
	input  wire        POWER_DOWN_PIN_N,
	input  wire        FC_PIN,
	input  wire        SDATA_IN,
	output reg         SCLK_OUT,
	output reg         FRAME_SYNC_OUT,
	output reg         SDATA_OUT,
	output reg         SDATA_OUT_OE,
	input  wire [15:0] ADC_DATA,
	input  wire        ADC_VALID,
	output reg         ADC_READY,
	output reg  [15:0] DAC_DATA,
	output reg         DAC_VALID,
	input  wire        OVF_EVENT,
	output reg         FLAG0_OUT,
	output reg         FLAG1_OUT,
	output reg         PHONE_MODE,
	output reg         SW_PWRDN,
	output reg         AUX_SEL,
	output reg         LOOPBACK_EN,
	output reg         MODE_15BIT,
	output reg  [1:0]  MONITOR_SEL
);

////////////////////////////////////////////////////////////////////////
// pin synchronisers

reg        pd_s1_reg;
reg        pd_s2_reg;
reg        fc_s1_reg;
reg        fc_s2_reg;
reg        din_s1_reg;
reg        din_s2_reg;

always @(posedge CLK) begin
	if (RST) begin
		pd_s1_reg  <= 1'b1;
		pd_s2_reg  <= 1'b1;
		fc_s1_reg  <= 1'b0;
		fc_s2_reg  <= 1'b0;
		din_s1_reg <= 1'b0;
		din_s2_reg <= 1'b0;
	end else if (CE) begin
		pd_s1_reg  <= POWER_DOWN_PIN_N;
		pd_s2_reg  <= pd_s1_reg;
		fc_s1_reg  <= FC_PIN;
		fc_s2_reg  <= fc_s1_reg;
		din_s1_reg <= SDATA_IN;
		din_s2_reg <= din_s1_reg;
	end
end

////////////////////////////////////////////////////////////////////////
// resets

reg        swrst_reg;
wire       reg_rst;
wire       cnt_rst;

assign reg_rst = RST | swrst_reg;
assign cnt_rst = reg_rst | ~pd_s2_reg;

////////////////////////////////////////////////////////////////////////
// state shared between processes

reg [`CSP_CNT_W-1:0] cnt_reg;
reg [4:0]            bitk_reg;
reg                  in_frame_reg;
reg                  is_sec_reg;
reg                  done_reg;
reg                  cap_d1_reg;
reg                  cap_d2_reg;
reg                  sec_pend_reg;
reg [15:0]           tx_sh_reg;
reg [15:0]           rx_sh_reg;
reg [15:0]           pri_word_reg;
reg [15:0]           rd_word_reg;
reg [7:0]            ctrl1_reg;
reg [7:0]            ctrl2_reg;
reg [15:0]           last_sec_reg;

reg [15:0]           buf_mem_reg [0:`CSP_BUF_DEPTH-1];
reg                  buf_wp_reg;
reg                  buf_rp_reg;
reg [1:0]            buf_cnt_reg;

wire start_pri;
wire start_sec;
wire rise_slot;
wire buf_push;
wire buf_pop;
wire av_wr_cmd;
wire [15:0] pri_out;

assign rise_slot = (cnt_reg[0] == 1'b0);
// one primary start per sample period
assign start_pri = (cnt_reg == `CSP_PRI_START);
assign start_sec = (cnt_reg == `CSP_SEC_START) & sec_pend_reg;
assign buf_push = ADC_VALID & ADC_READY;
assign buf_pop = start_pri & (buf_cnt_reg != 2'h0);
assign av_wr_cmd = AVS_WRITE & ~AVS_WAITREQUEST & (AVS_ADDRESS == `CSP_AV_CMD);

// 15-bit mode forces the lsb low; an empty buffer sends zero
assign pri_out = (buf_cnt_reg == 2'h0) ? 16'h0000 :
	{buf_mem_reg[buf_rp_reg][15:1], buf_mem_reg[buf_rp_reg][0] & ~ctrl1_reg[`CSP_C1_M15]};

////////////////////////////////////////////////////////////////////////
// adc buffer: stalls the source when both entries wait for a frame

reg [1:0] buf_cnt_next;

always @* begin
	buf_cnt_next = buf_cnt_reg;
	if (buf_push & ~buf_pop)
		buf_cnt_next = buf_cnt_reg + 2'h1;
	else if (buf_pop & ~buf_push)
		buf_cnt_next = buf_cnt_reg - 2'h1;
end

always @(posedge CLK) begin
	if (reg_rst) begin
		buf_wp_reg     <= 1'b0;
		buf_rp_reg     <= 1'b0;
		buf_cnt_reg    <= 2'h0;
		ADC_READY      <= 1'b0;
		buf_mem_reg[0] <= 16'h0000;
		buf_mem_reg[1] <= 16'h0000;
	end else if (CE) begin
		if (buf_push) begin
			buf_mem_reg[buf_wp_reg] <= ADC_DATA;
			buf_wp_reg <= ~buf_wp_reg;
		end
		if (buf_pop)
			buf_rp_reg <= ~buf_rp_reg;
		buf_cnt_reg <= buf_cnt_next;
		ADC_READY   <= (buf_cnt_next != 2'h2);
	end
end

////////////////////////////////////////////////////////////////////////
// shift clock, frame sync and shifters

always @(posedge CLK) begin
	if (cnt_rst) begin
		cnt_reg        <= {`CSP_CNT_W{1'b0}};
		bitk_reg       <= 5'h00;
		in_frame_reg   <= 1'b0;
		is_sec_reg     <= 1'b0;
		done_reg       <= 1'b0;
		cap_d1_reg     <= 1'b0;
		cap_d2_reg     <= 1'b0;
		tx_sh_reg      <= 16'h0000;
		rx_sh_reg      <= 16'h0000;
		pri_word_reg   <= 16'h0000;
		SCLK_OUT       <= 1'b0;
		FRAME_SYNC_OUT <= 1'b1;
		SDATA_OUT      <= 1'b0;
		SDATA_OUT_OE   <= 1'b0;
	end else if (CE) begin
		// shift clock is CLK divided by two
		cnt_reg  <= cnt_reg + {{(`CSP_CNT_W-1){1'b0}}, 1'b1};
		SCLK_OUT <= rise_slot;
		// the input synchroniser delays din by two cycles, so capture trails the frame
		cap_d1_reg <= in_frame_reg;
		cap_d2_reg <= cap_d1_reg;
		done_reg   <= cap_d2_reg & ~cap_d1_reg;
		// sixteen input bits, one per shift period
		if (~rise_slot & cap_d2_reg)
			rx_sh_reg <= {rx_sh_reg[14:0], din_s2_reg};
		if (rise_slot) begin
			if (start_pri | start_sec) begin
				FRAME_SYNC_OUT <= 1'b0;
				in_frame_reg   <= 1'b1;
				is_sec_reg     <= start_sec;
				bitk_reg       <= 5'h01;
				// adc word leaves in a primary
				tx_sh_reg      <= start_sec ? rd_word_reg : pri_out;
				SDATA_OUT      <= start_sec ? rd_word_reg[15] : pri_out[15];
				SDATA_OUT_OE   <= 1'b1;
				if (start_pri)
					pri_word_reg <= pri_out;
			end else if (in_frame_reg) begin
				tx_sh_reg <= {tx_sh_reg[14:0], 1'b0};
				bitk_reg  <= bitk_reg + 5'h01;
				if (bitk_reg == `CSP_FRAME_EDGES) begin
					// sync rises on the seventeenth edge
					FRAME_SYNC_OUT <= 1'b1;
					SDATA_OUT_OE   <= 1'b0;
					SDATA_OUT      <= 1'b0;
					in_frame_reg   <= 1'b0;
				end else begin
					SDATA_OUT <= tx_sh_reg[14];
				end
			end
		end
	end
end

// pending request is counter state: a power-down drops it
always @(posedge CLK) begin
	if (cnt_rst) begin
		sec_pend_reg <= 1'b0;
	end else if (CE) begin
		if (av_wr_cmd & AVS_WRITEDATA[`CSP_CMD_SECREQ])
			sec_pend_reg <= 1'b1;
		else if (done_reg & ~is_sec_reg & fc_s2_reg)
			sec_pend_reg <= 1'b1;
		else if (start_sec & rise_slot)
			sec_pend_reg <= 1'b0;
	end
end

////////////////////////////////////////////////////////////////////////
// control registers and frame commits

wire [1:0] sec_addr;
wire       sec_rd;
wire [7:0] sec_data;
wire       sec_commit;
wire       rd_c2;

assign sec_addr   = rx_sh_reg[`CSP_SEC_ADDR_HI:`CSP_SEC_ADDR_LO];
assign sec_rd     = rx_sh_reg[`CSP_SEC_RD_BIT];
assign sec_data   = rx_sh_reg[`CSP_SEC_DATA_HI:`CSP_SEC_DATA_LO];
assign sec_commit = done_reg & is_sec_reg;
assign rd_c2      = sec_commit & sec_rd & (sec_addr == `CSP_ADDR_CTRL2);

always @(posedge CLK) begin
	if (reg_rst) begin
		ctrl1_reg    <= `CSP_C1_RESET;
		ctrl2_reg    <= `CSP_C2_RESET;
		rd_word_reg  <= 16'h0000;
		last_sec_reg <= 16'h0000;
		swrst_reg    <= 1'b0;
		DAC_DATA     <= 16'h0000;
		DAC_VALID    <= 1'b0;
	end else if (CE) begin
		DAC_VALID <= 1'b0;
		// a new overflow beats the read clear
		ctrl2_reg[`CSP_C2_OVF] <= OVF_EVENT | (ctrl2_reg[`CSP_C2_OVF] & ~rd_c2);
		if (done_reg & ~is_sec_reg) begin
			// dac word lands at frame end
			DAC_DATA  <= ctrl1_reg[`CSP_C1_LOOP] ? pri_word_reg : rx_sh_reg;
			DAC_VALID <= 1'b1;
		end
		if (start_sec & rise_slot)
			rd_word_reg <= 16'h0000;
		if (sec_commit) begin
			last_sec_reg <= rx_sh_reg;
			if (sec_rd) begin
				case (sec_addr)
				`CSP_ADDR_CTRL1: rd_word_reg <= {8'h00, ctrl1_reg};
				`CSP_ADDR_CTRL2: rd_word_reg <= {8'h00, ctrl2_reg};
				default:         rd_word_reg <= 16'h0000;
				endcase
			end else begin
				// address 0 and 3 change nothing
				case (sec_addr)
				`CSP_ADDR_CTRL1: begin
					ctrl1_reg <= sec_data;
					swrst_reg <= sec_data[`CSP_C1_SWRST];
				end
				`CSP_ADDR_CTRL2: begin
					ctrl2_reg[`CSP_C2_PHONE] <= sec_data[`CSP_C2_PHONE];
					ctrl2_reg[`CSP_C2_FLAG1] <= sec_data[`CSP_C2_FLAG1];
					ctrl2_reg[`CSP_C2_FLAG0] <= sec_data[`CSP_C2_FLAG0];
				end
				default: begin
				end
				endcase
			end
		end
	end
end

// control outputs; flags only reach the pins in phone mode
always @(posedge CLK) begin
	if (reg_rst) begin
		FLAG0_OUT   <= 1'b0;
		FLAG1_OUT   <= 1'b0;
		PHONE_MODE  <= 1'b0;
		SW_PWRDN    <= 1'b0;
		AUX_SEL     <= 1'b0;
		LOOPBACK_EN <= 1'b0;
		MODE_15BIT  <= 1'b0;
		MONITOR_SEL <= 2'h0;
	end else if (CE) begin
		PHONE_MODE  <= ctrl2_reg[`CSP_C2_PHONE];
		FLAG0_OUT   <= ctrl2_reg[`CSP_C2_PHONE] & ctrl2_reg[`CSP_C2_FLAG0];
		FLAG1_OUT   <= ctrl2_reg[`CSP_C2_PHONE] & ctrl2_reg[`CSP_C2_FLAG1];
		SW_PWRDN    <= ctrl1_reg[`CSP_C1_SWPD];
		AUX_SEL     <= ctrl1_reg[`CSP_C1_AUX];
		LOOPBACK_EN <= ctrl1_reg[`CSP_C1_LOOP];
		MODE_15BIT  <= ctrl1_reg[`CSP_C1_M15];
		MONITOR_SEL <= ctrl1_reg[`CSP_C1_MON_HI:`CSP_C1_MON_LO];
	end
end

////////////////////////////////////////////////////////////////////////
// avalon-mm slave: one wait cycle, then a single-cycle answer

reg [31:0] rdata_next;

always @* begin
	rdata_next = 32'h00000000;
	case (AVS_ADDRESS)
	`CSP_AV_STATUS:
		rdata_next = {8'h00, ctrl2_reg, ctrl1_reg, 4'h0,
			in_frame_reg, sec_pend_reg, ~pd_s2_reg, is_sec_reg};
	`CSP_AV_LASTSEC:
		rdata_next = {16'h0000, last_sec_reg};
	default:
		rdata_next = 32'h00000000;
	endcase
end

// RST only: a software reset must not cut a bus cycle short
always @(posedge CLK) begin
	if (RST) begin
		AVS_WAITREQUEST <= 1'b1;
		AVS_READDATA    <= 32'h00000000;
	end else if (CE) begin
		if ((AVS_READ | AVS_WRITE) & AVS_WAITREQUEST) begin
			AVS_WAITREQUEST <= 1'b0;
			AVS_READDATA    <= AVS_READ ? rdata_next : 32'h00000000;
		end else begin
			AVS_WAITREQUEST <= 1'b1;
			AVS_READDATA    <= 32'h00000000;
		end
	end
end

endmodule

`default_nettype wire

/* File: verif/csp_assertions.sv */
// checker on the ports of the codec serial port top
// bound into csp_top; the bench holds CE high throughout
`timescale 1ns/10ps
`default_nettype none
module csp_assertions (
	input wire logic        CLK,
	input wire logic        RST,
	input wire logic        POWER_DOWN_PIN_N,
	input wire logic        AVS_READ,
	input wire logic        AVS_WRITE,
	input wire logic        AVS_WAITREQUEST,
	input wire logic [31:0] AVS_READDATA,
	input wire logic        SCLK_OUT,
	input wire logic        FRAME_SYNC_OUT,
	input wire logic        SDATA_OUT,
	input wire logic        SDATA_OUT_OE
);
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RST);
	logic [9:0] gap_reg;
	logic       seen_reg;
	// the pin restarts the counters, so the gap is only trusted after a fresh fall
	always @(posedge CLK) begin
		if (RST || !POWER_DOWN_PIN_N) begin
			gap_reg  <= 10'h000;
			seen_reg <= 1'h0;
		end else if ($fell(FRAME_SYNC_OUT)) begin
			gap_reg  <= 10'h001;
			seen_reg <= 1'h1;
		end else if (gap_reg != 10'h3ff) begin
			gap_reg <= gap_reg + 10'h001;
		end
	end
	////////////////////////////////////////////////////////////////
	property p_frame_len;
		disable iff (RST || !POWER_DOWN_PIN_N)
		$fell(FRAME_SYNC_OUT) |-> (!FRAME_SYNC_OUT)[*8] ##24 !FRAME_SYNC_OUT ##1 FRAME_SYNC_OUT;
	endproperty
	a_frame_len: assert property (p_frame_len) else $error("frame length");
	property p_fs_sclk;
		$fell(FRAME_SYNC_OUT) |-> $rose(SCLK_OUT);
	endproperty
	a_fs_sclk: assert property (p_fs_sclk) else $error("frame start off shift edge");
	property p_sclk_run;
		!FRAME_SYNC_OUT && !$past(FRAME_SYNC_OUT) |-> SCLK_OUT != $past(SCLK_OUT);
	endproperty
	a_sclk_run: assert property (p_sclk_run) else $error("shift clock stalled");
	property p_period;
		$fell(FRAME_SYNC_OUT) && seen_reg |-> gap_reg == 10'h100 || gap_reg == 10'h200;
	endproperty
	a_period: assert property (p_period) else $error("frame spacing");
	property p_oe_frame;
		SDATA_OUT_OE == !FRAME_SYNC_OUT;
	endproperty
	a_oe_frame: assert property (p_oe_frame) else $error("output enable outside frame");
	property p_out_idle;
		!SDATA_OUT_OE |-> !SDATA_OUT;
	endproperty
	a_out_idle: assert property (p_out_idle) else $error("data while released");
	property p_pd_idle;
		(!POWER_DOWN_PIN_N)[*4] |-> FRAME_SYNC_OUT && !SDATA_OUT_OE && !SCLK_OUT;
	endproperty
	a_pd_idle: assert property (p_pd_idle) else $error("port active in power-down");
	property p_wait_ans;
		(AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
	endproperty
	a_wait_ans: assert property (p_wait_ans) else $error("bus answer timing");
	property p_rdata_idle;
		AVS_WAITREQUEST |-> AVS_READDATA == 32'h0;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer");
endmodule
bind csp_top csp_assertions u_chk (.*);
`default_nettype wire

/* File: verif/csp_host_model.sv */
// host serial port: sends one word per frame, collects the returned word
// assumes the device makes the shift clock and frame sync
`timescale 1ns/10ps
`default_nettype none
module csp_host_model (
	input  wire logic        sclk,
	input  wire logic        fs_n,
	input  wire logic        dout,
	input  wire logic [15:0] tx_word,
	output var  logic        din,
	output var  logic [15:0] rx_word,
	output var  logic [15:0] frames
);
	logic [3:0]  bit_reg = 4'h0;
	logic [15:0] sh_reg  = 16'h0;
	initial begin
		din     = 1'h0;
		rx_word = 16'h0;
		frames  = 16'h0;
	end
	always @(posedge sclk) begin
		if (!fs_n) begin
			din     <= tx_word[4'hf - bit_reg];
			bit_reg <= bit_reg + 4'h1;
		end else begin
			// no valid bit between frames, so keep the line moving
			din     <= ~din;
			bit_reg <= 4'h0;
		end
	end
	// frame start and first shift edge coincide: put the msb out on the fall itself
	always @(negedge fs_n) begin
		din     <= tx_word[15];
		bit_reg <= 4'h1;
	end
	always @(negedge sclk) begin
		if (!fs_n)
			sh_reg <= {sh_reg[14:0], dout};
	end
	always @(posedge fs_n) begin
		rx_word <= sh_reg;
		frames  <= frames + 16'h1;
	end
endmodule
`default_nettype wire

/* File: verif/csp_top_tb_top.sv */
// self-checking bench for csp_top with a host serial port model
// one clock; CE held high; the data pin is resolved here
`timescale 1ns/10ps
`default_nettype none
module csp_top_tb_top;
	logic        CLK, RST, CE, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, POWER_DOWN_PIN_N, FC_PIN;
	logic        SCLK_OUT, FRAME_SYNC_OUT, SDATA_OUT, SDATA_OUT_OE, ADC_VALID, ADC_READY, DAC_VALID;
	logic        OVF_EVENT, FLAG0_OUT, FLAG1_OUT, PHONE_MODE, SW_PWRDN, AUX_SEL, LOOPBACK_EN, MODE_15BIT;
	logic [1:0]  MONITOR_SEL;
	logic [3:0]  AVS_ADDRESS;
	logic [31:0] AVS_WRITEDATA, AVS_READDATA, q;
	logic [15:0] ADC_DATA, DAC_DATA, rx, frames, tx, sw, w0, w1, rg, f, rb;
	logic [1:0]  ads [6] = '{2'h1, 2'h2, 2'h0, 2'h3, 2'h1, 2'h2};
	wire         SDATA_IN;
	wire         pin = SDATA_OUT_OE ? SDATA_OUT : 1'bz;
	integer      seed, fails, checked, i;
	csp_top uut (.*);
	csp_host_model host (.sclk(SCLK_OUT), .fs_n(FRAME_SYNC_OUT), .dout(pin), .tx_word(tx),
		.din(SDATA_IN), .rx_word(rx), .frames(frames));
	initial begin
		CLK = 1'h0;
		forever #50 CLK = ~CLK;
	end
	////////////////////////////////////////////////////////////////
	task finish_test;
		if (fails == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			fails++;
			$display("CHECK FAILED %0t: got %h expected %h", $time, s, e);
		end
	endtask
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
		int k;
		k = 0;
		AVS_ADDRESS <= a;
		AVS_WRITEDATA <= d;
		AVS_WRITE <= w;
		AVS_READ <= !w;
		do begin
			@(posedge CLK);
			k++;
		end while (AVS_WAITREQUEST !== 1'h0 && k < 50);
		r = AVS_READDATA;
		AVS_READ <= 1'h0;
		AVS_WRITE <= 1'h0;
		@(posedge CLK);
		if (k >= 50) begin
			fails++;
			finish_test;
		end
	endtask
	// fr low waits for a primary to hand over its word, high for any frame end
	task wait_ev(input logic fr);
		logic [15:0] f0;
		int          k;
		f0 = frames;
		k = 0;
		do begin
			@(posedge CLK);
			k++;
		end while ((fr ? frames === f0 : DAC_VALID !== 1'h1) && k < 2000);
		if (k >= 2000) begin
			fails++;
			finish_test;
		end
	endtask
	function logic [15:0] regs_after(input logic [15:0] w, input logic [15:0] r);
		regs_after = r;
		if (!w[13] && w[9:8] == 2'h1)
			regs_after[7:0] = w[7:0];
		if (!w[13] && w[9:8] == 2'h2)
			regs_after[15:8] = {r[15], 4'h0, w[2:0]};
		if (w[13] && w[9:8] == 2'h2)
			regs_after[15] = 1'h0;
	endfunction
	task reg_chk;
		bus(1'h0, 4'h0, 32'h0, q);
		chk(q[23:8], rg);
		chk({SW_PWRDN, AUX_SEL, LOOPBACK_EN, MODE_15BIT, MONITOR_SEL}, rg[6:1]);
		chk({PHONE_MODE, FLAG1_OUT, FLAG0_OUT}, {rg[10], rg[9] & rg[10], rg[8] & rg[10]});
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		seed = 53374;
		fails = 0;
		checked = 0;
		{CE, RST, POWER_DOWN_PIN_N} = 3'h7;
		{AVS_READ, AVS_WRITE, FC_PIN, ADC_VALID, OVF_EVENT} = 5'h0;
		AVS_ADDRESS = 4'h0;
		AVS_WRITEDATA = 32'h0;
		ADC_DATA = 16'h0;
		rg = 16'h0;
		tx = $random(seed);
		repeat (16) @(posedge CLK);
		RST <= 1'h0;
		@(posedge CLK);
		reg_chk;
		bus(1'h0, 4'hc, 32'h0, q);
		chk(q, 32'h0);
		bus(1'h1, 4'hc, 32'hffffffff, q);
		wait_ev(1'h0);
		w0 = $random(seed);
		w1 = $random(seed);
		ADC_VALID <= 1'h1;
		ADC_DATA <= w0;
		@(posedge CLK);
		ADC_DATA <= w1;
		@(posedge CLK);
		ADC_VALID <= 1'h0;
		repeat (2) @(posedge CLK);
		chk(ADC_READY, 1'h0);
		for (i = 0; i < 3; i++) begin
			wait_ev(1'h0);
			chk(DAC_DATA, tx);
			chk(rx, i == 0 ? w0 : i == 1 ? w1 : 16'h0);
			tx = $random(seed);
		end
		chk(ADC_READY, 1'h1);
		rb = 16'h0;
		for (i = 0; i < 6; i++) begin
			sw = {2'h0, i > 3, 3'h0, ads[i], 8'($random(seed)) & 8'h7f};
			if (i == 5) begin
				OVF_EVENT <= 1'h1;
				@(posedge CLK);
				OVF_EVENT <= 1'h0;
				rg[15] = 1'h1;
				reg_chk;
			end
			wait_ev(1'h0);
			tx = sw;
			if (i % 2)
				FC_PIN <= 1'h1;
			else
				bus(1'h1, 4'h4, 32'h1, q);
			if (i % 2) begin
				wait_ev(1'h0);
				FC_PIN <= 1'h0;
			end
			reg_chk;
			wait_ev(1'h1);
			repeat (3) @(posedge CLK);
			chk(rx, rb);
			bus(1'h0, 4'h8, 32'h0, q);
			chk(q, {16'h0, sw});
			rb = !sw[13] ? 16'h0 : sw[9:8] == 2'h1 ? {8'h0, rg[7:0]} : sw[9:8] == 2'h2 ? {8'h0, rg[15:8]} : 16'h0;
			rg = regs_after(sw, rg);
			reg_chk;
		end
		wait_ev(1'h0);
		POWER_DOWN_PIN_N <= 1'h0;
		repeat (5) @(posedge CLK);
		f = frames;
		repeat (600) @(posedge CLK);
		chk(frames, f);
		bus(1'h0, 4'h0, 32'h0, q);
		chk(q[1], 1'h1);
		reg_chk;
		POWER_DOWN_PIN_N <= 1'h1;
		wait_ev(1'h0);
		reg_chk;
		finish_test;
	end
endmodule
`default_nettype wire
